/* File: accel_mode_and_data_format.sv */
// power-mode control and output data formatting for a three-axis sensor
`timescale 1ns/10ps
module accel_mode_and_data_format
  import accel_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES  = BOOT_CYC,       // boot wait, shortenable
  parameter int unsigned EXTRA_CYCLES = WAKE_EXTRA_CYC, // 1 ms wake extra, shortenable
  parameter int unsigned EVENTS       = 4               // event sources routed to pins
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 supply_ok,        // supply above off threshold (pin)
  input  wire ctrl_s                ctrl,             // control_one / control_two bits
  input  wire logic                 sample_tick,      // one per output_rate period
  input  wire logic                 sleep_req,        // from auto-sleep logic
  input  wire logic                 wake_req,         // from auto-wake logic
  input  wire sample_t              raw [NUM_AXES],   // converter results
  input  wire sample_t              user_offset [NUM_AXES],
  input  wire logic                 offset_wr,        // host writes offsets
  input  wire logic [EVENTS-1:0]    events,           // detector levels
  input  wire logic [EVENTS-1:0]    event_route,      // 1 routes to pin two
  output logic [1:0]                trim_addr,        // trim_store address
  input  wire trim_s                trim_data,        // trim_store data
  output logic                      bus_ready,        // serial access serviced
  output logic                      analog_en,        // analog subsystem on
  output logic                      clocks_en,        // internal clocks on
  output mode_e                     mode,             // present power mode
  output logic                      data_valid_r,     // output registers hold good data
  output out_pair_s                 out [NUM_AXES],   // per-axis output registers
  output range_e                    eff_range,        // range used for data and thresholds
  output logic [1:0]                eff_ovs,          // oversampling in use
  output logic                      low_power,        // lowest-power oversampling
  output logic [15:0]               lsb_ug,           // micro-g per 14-bit count
  output logic                      int_one_r,        // interrupt pin one
  output logic                      int_two_r         // interrupt pin two
);
  // elaboration guards on the parameters
  if (EVENTS < 1) begin : g_bad_events
    $error("need at least one event source");
  end
  if (BOOT_CYCLES < 1 || EXTRA_CYCLES < 1) begin : g_bad_counts
    $error("counts must be positive");
  end

  // supply and control pins come from outside the clock domain
  logic        sup_s1_r, sup_s2_r;   // supply synchroniser
  ctrl_s       ctl_s1_r, ctl_s2_r;   // control synchroniser
  logic [1:0]  slw_s1_r, slw_s2_r;   // sleep/wake request synchroniser

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
      ctl_s1_r <= '0;
      ctl_s2_r <= '0;
      slw_s1_r <= 2'h0;
      slw_s2_r <= 2'h0;
    end else begin
      sup_s1_r <= supply_ok;
      sup_s2_r <= sup_s1_r;
      ctl_s1_r <= ctrl;
      ctl_s2_r <= ctl_s1_r;
      slw_s1_r <= {sleep_req, wake_req};
      slw_s2_r <= slw_s1_r;
    end
  end

  // boot counter: bus held off until the counter runs out and the trim load finishes
  localparam int unsigned BW = $clog2(BOOT_CYCLES + 1);
  logic [BW-1:0] boot_cnt_r;   // cycles since supply good
  logic          booted_r;     // boot finished

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_cnt_r <= '0;
      booted_r   <= 1'b0;
    end else if (!sup_s2_r) begin
      boot_cnt_r <= '0;          // power loss restarts the boot
      booted_r   <= 1'b0;
    end else if (!booted_r) begin
      if (boot_cnt_r == BW'(BOOT_CYCLES - 1)) begin
        booted_r <= 1'b1;
      end
      boot_cnt_r <= boot_cnt_r + BW'(1);
    end
  end

  // trim loader starts once the boot has finished
  trim_s trim [NUM_AXES];   // loaded trim per axis
  logic  trim_done;         // all axes loaded

  accel_trim_loader #(
    .AXES      (NUM_AXES)
  ) u_trim (
    .core_clk  (core_clk),
    .rst       (rst),
    .start     (booted_r),
    .trim_addr (trim_addr),
    .trim_data (trim_data),
    .trim_r    (trim),
    .done_r    (trim_done)
  );

  // power mode state
  mode_e mode_r, mode_nxt;   // present and next mode
  logic  enter_active;       // standby to active this cycle

  // mode decision; off wins, then the active bit
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_OFF: begin
        if (booted_r && trim_done) begin
          mode_nxt = MODE_STANDBY;
        end
      end
      MODE_STANDBY: begin
        if (ctl_s2_r.active) begin
          mode_nxt = MODE_WAKE;
        end
      end
      MODE_WAKE: begin
        if (!ctl_s2_r.active) begin
          mode_nxt = MODE_STANDBY;
        end else if (slw_s2_r[1]) begin
          mode_nxt = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (!ctl_s2_r.active) begin
          mode_nxt = MODE_STANDBY;
        end else if (slw_s2_r[0]) begin
          mode_nxt = MODE_WAKE;
        end
      end
      default: begin
        mode_nxt = MODE_OFF;
      end
    endcase
    if (!sup_s2_r) begin
      mode_nxt = MODE_OFF;
    end
  end

  // mode register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign enter_active = (mode_r == MODE_STANDBY) && (mode_nxt == MODE_WAKE);
  assign mode         = mode_r;

  // standby: digital only, bus still serviced
  assign bus_ready = (mode_r != MODE_OFF);
  // sleep and wake both count as active
  assign analog_en = (mode_r == MODE_WAKE) || (mode_r == MODE_SLEEP);
  assign clocks_en = analog_en;

  // configuration latched on entry to active, so mid-run edits cannot tear data
  ctrl_s cfg_r;   // settings in use

  // settings latched on the standby-to-active edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (enter_active) begin
      cfg_r <= ctl_s2_r;
    end
  end

  // range and scale decode
  // low noise pins the range at 4 g
  assign eff_range = cfg_r.low_noise ? RANGE_4G : cfg_r.range;
  // oversampling only reaches output, not range
  assign eff_ovs   = cfg_r.ovs_mode;
  assign low_power = (cfg_r.ovs_mode == OVS_LOW_POWER);

  // scale per count; 4 g sits between the two printed figures
  always_comb begin
    case (eff_range)
      RANGE_2G: lsb_ug = 16'(LSB_2G_UG);
      RANGE_8G: lsb_ug = 16'(LSB_8G_UG);
      default:  lsb_ug = 16'(LSB_2G_UG * 2);
    endcase
  end

  // wake wait: two output periods, then the extra time
  localparam int unsigned EW = $clog2(EXTRA_CYCLES + 1);
  logic [1:0]    tick_cnt_r;    // output periods seen
  logic [EW-1:0] extra_cnt_r;   // extra cycles counted

  // valid data after two periods plus extra
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r   <= 2'h0;
      extra_cnt_r  <= '0;
      data_valid_r <= 1'b0;
    end else if (!analog_en || enter_active) begin
      tick_cnt_r   <= 2'h0;
      extra_cnt_r  <= '0;
      if (enter_active) begin
        data_valid_r <= 1'b0;
      end
    end else if (!data_valid_r) begin
      if (tick_cnt_r < 2'(WAKE_PERIODS)) begin
        if (sample_tick) begin
          tick_cnt_r <= tick_cnt_r + 2'h1;
        end
      end else if (extra_cnt_r == EW'(EXTRA_CYCLES - 1)) begin
        data_valid_r <= 1'b1;
      end else begin
        extra_cnt_r <= extra_cnt_r + EW'(1);
      end
    end
  end

  // user offset registers; kept across mode changes
  sample_t uoff_r [NUM_AXES];   // host offsets

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        uoff_r[a] <= OFFSET_RST;
      end
    end else if (offset_wr && bus_ready) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        uoff_r[a] <= user_offset[a];
      end
    end
  end

  // per-axis formatting; data registers are the reset-on-activate set
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_fmt
    // data cleared on standby to active
    accel_axis_format u_fmt (
      .core_clk    (core_clk),
      .rst         (rst),
      .load        (sample_tick && analog_en && data_valid_r),
      .clear       (enter_active),
      .raw         (raw[a]),
      .trim        (trim[a]),
      .user_offset (uoff_r[a]),
      .upper_only  (cfg_r.upper_only),
      .out_r       (out[a])
    );
  end

  // event routing to the two pins, only while active
  logic [EVENTS-1:0] ev_s1_r, ev_s2_r;   // event synchroniser

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_s1_r <= '0;
      ev_s2_r <= '0;
    end else begin
      ev_s1_r <= events;
      ev_s2_r <= ev_s1_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_one_r <= 1'b0;
      int_two_r <= 1'b0;
    end else begin
      int_one_r <= analog_en && |(ev_s2_r & ~event_route);
      int_two_r <= analog_en && |(ev_s2_r & event_route);
    end
  end
endmodule

/* File: accel_pkg.sv */
// shared constants and carrier types for the acceleration mode/format block
package accel_pkg;
  localparam int unsigned SAMPLE_W      = 14;                 // full result width
  localparam int unsigned UPPER_W       = 8;                  // upper byte width
  localparam int unsigned LOWER_PAD     = 2;                  // unused low bits of lower byte
  localparam int unsigned NUM_AXES      = 3;                  // x, y, z
  localparam int unsigned CLK_HZ        = 40_000_000;         // core clock rate
  localparam int unsigned BOOT_US       = 1000;               // longest boot time, us
  localparam int unsigned BOOT_CYC      = BOOT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_EXTRA_MS = 1;                  // standby to active extra, ms
  localparam int unsigned WAKE_EXTRA_CYC = WAKE_EXTRA_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_PERIODS  = 2;                  // output periods before valid
  localparam int unsigned RES_FACTOR    = 64;                 // 14-bit vs 8-bit step ratio
  localparam int unsigned LSB_2G_UG     = 244;                // ug per count, 2 g range
  localparam int unsigned LSB_8G_UG     = 976;                // ug per count, 8 g range
  localparam logic [7:0]  LOW_NOISE_LOC = 8'h2A;              // low-noise control location
  localparam logic [1:0]  OVS_LOW_POWER = 2'h0;               // lowest-power oversampling mode
  localparam logic [13:0] OFFSET_RST    = 14'h0000;           // user offset reset value
  localparam logic [13:0] SAMPLE_RST    = 14'h0000;           // sample reset value

  // full-scale range selections
  typedef enum logic [1:0] {RANGE_2G, RANGE_4G, RANGE_8G} range_e;
  // power modes
  typedef enum logic [1:0] {MODE_OFF, MODE_STANDBY, MODE_WAKE, MODE_SLEEP} mode_e;

  // one axis worth of data
  typedef logic signed [SAMPLE_W-1:0] sample_t;

  // host-visible configuration bits
  typedef struct packed {
    logic       active;      // active control bit
    logic       upper_only;  // upper-byte-only read
    logic       low_noise;   // low-noise setting
    range_e     range;       // full-scale range
    logic [1:0] ovs_mode;    // oversampling selection
  } ctrl_s;

  // trim values per axis
  typedef struct packed {
    sample_t gain_adj;       // sensitivity trim (signed, 1/8192 units)
    sample_t offset;         // offset trim
  } trim_s;

  // output register pair
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } out_pair_s;
endpackage

/* File: accel_trim_loader.sv */
// startup loader that walks the trim store once per axis
`timescale 1ns/10ps
module accel_trim_loader
  import accel_pkg::*;
#(
  parameter int unsigned AXES = NUM_AXES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  output logic [1:0]                trim_addr,
  input  wire trim_s                trim_data,
  output trim_s                     trim_r [AXES],
  output logic                      done_r
);
  // elaboration guard: the index is only two bits wide
  if (AXES < 1 || AXES > 4) begin : g_bad_axes
    $error("axis count unsupported");
  end

  logic [1:0] idx_r;   // axis being read
  logic       busy_r;  // walk in progress

  assign trim_addr = idx_r;

  // walk sequencer: one axis per cycle, store answers combinationally
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_r  <= 2'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start && !busy_r && !done_r) begin
      busy_r <= 1'b1;
      idx_r  <= 2'h0;
    end else if (busy_r) begin
      if (idx_r == 2'(AXES - 1)) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        idx_r <= idx_r + 2'h1;
      end
    end
  end

  // capture storage; zero until loaded
  for (genvar a = 0; a < AXES; a++) begin : g_axis
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        trim_r[a] <= '0;
      end else if (busy_r && idx_r == 2'(a)) begin
        trim_r[a] <= trim_data;
      end
    end
  end
endmodule

/* File: accel_axis_format.sv */
// per-axis compensation and output byte formatting
`timescale 1ns/10ps
module accel_axis_format
  import accel_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    rst,
  input  wire logic    load,
  input  wire logic    clear,
  input  wire sample_t raw,
  input  wire trim_s   trim,
  input  wire sample_t user_offset,
  input  wire logic    upper_only,
  output out_pair_s    out_r
);
  logic signed [27:0] scaled;   // raw times trim gain
  logic signed [15:0] sum;      // compensated with headroom
  sample_t            sat;      // clamped to 14 bits

  // gain trim then offsets; saturate rather than wrap
  always_comb begin
    scaled = 28'(raw) * 28'(trim.gain_adj);
    sum    = 16'(raw) + 16'(scaled >>> 13) + 16'(trim.offset) + 16'(user_offset);
    if (sum > 16'sd8191) begin
      sat = 14'h1FFF;
    end else if (sum < -16'sd8192) begin
      sat = 14'h2000;
    end else begin
      sat = sum[SAMPLE_W-1:0];
    end
  end

  // output register pair, upper holds top 8 bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_r <= '0;
    end else if (clear) begin
      out_r <= '0;
    end else if (load) begin
      out_r.upper <= sat[SAMPLE_W-1 -: UPPER_W];
      // lower byte dropped in upper-only mode: 64x coarser step
      out_r.lower <= upper_only ? 8'h00 : {sat[SAMPLE_W-UPPER_W-1:0], {LOWER_PAD{1'b0}}};
    end
  end
endmodule

/* File: trim_store_model.sv */
// trim store model answering the loader in the same cycle
`timescale 1ns/10ps
module trim_store_model
  import accel_pkg::*;
#(
  parameter sample_t STEP = 14'h0010  // offset step per axis
) (
  input  wire logic [1:0] trim_addr,
  output trim_s           trim_data
);
  always_comb begin
    trim_data.gain_adj = '0;  // unity gain keeps expectations exact
    trim_data.offset   = sample_t'(STEP * (int'(trim_addr) + 1));
    // unused slot returns junk, not a friendly value
    if (trim_addr == 2'h3) begin
      trim_data = '1;
    end
  end
endmodule

/* File: accel_mode_checker.sv */
// assertion checker for the power-mode and data-format block
`timescale 1ns/10ps
module accel_mode_checker
  import accel_pkg::*;
#(
  parameter int unsigned EXTRA_CYCLES = WAKE_EXTRA_CYC,
  parameter int unsigned EVENTS       = 4
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire ctrl_s             ctrl,
  input wire logic [EVENTS-1:0] events,
  input wire logic [EVENTS-1:0] event_route,
  input wire logic              bus_ready,
  input wire logic              analog_en,
  input wire logic              clocks_en,
  input wire mode_e             mode,
  input wire logic              data_valid_r,
  input wire out_pair_s         out [NUM_AXES],
  input wire range_e            eff_range,
  input wire logic [1:0]        eff_ovs,
  input wire logic              low_power,
  input wire logic [15:0]       lsb_ug,
  input wire logic              int_two_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [31:0] act_cnt_r;  // cycles awake since last entry
  // count awake cycles, saturating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_cnt_r <= '0;
    end else if (mode inside {MODE_OFF, MODE_STANDBY}) begin
      act_cnt_r <= '0;
    end else if (act_cnt_r != '1) begin
      act_cnt_r <= act_cnt_r + 32'h0000_0001;
    end
  end
  a_standby_gates_off:
    assert property (mode == MODE_STANDBY |-> bus_ready && !analog_en && !clocks_en)
    else $error("standby left analog or clocks on");
  a_active_all_on:
    assert property (mode inside {MODE_WAKE, MODE_SLEEP} |-> bus_ready && analog_en && clocks_en)
    else $error("active mode without all blocks");
  a_off_bus_dead:
    assert property (mode == MODE_OFF |-> !bus_ready && !analog_en && !clocks_en)
    else $error("off mode still serviced");
  a_stop_keeps_out:
    assert property ((mode == MODE_STANDBY) [*2] |->
      $stable(out[0]) && $stable(out[1]) && $stable(out[2]))
    else $error("output changed in standby");
  a_start_clears_out:
    assert property (mode == MODE_STANDBY ##1 mode == MODE_WAKE |->
      ##1 (!data_valid_r && out[1] == '0))
    else $error("entry to active kept old data");
  a_valid_after_wait:
    assert property ($rose(data_valid_r) |-> act_cnt_r >= EXTRA_CYCLES + WAKE_PERIODS)
    else $error("data valid too early");
  a_range_scale:
    assert property (lsb_ug == (eff_range == RANGE_2G ? 16'h00F4 :
      eff_range == RANGE_8G ? 16'h03D0 : 16'h01E8))
    else $error("count weight wrong for range");
  a_entry_range:
    assert property (mode == MODE_STANDBY ##1 mode == MODE_WAKE |->
      eff_range == (ctrl.low_noise ? RANGE_4G : ctrl.range))
    else $error("range not latched or low noise ignored");
  a_entry_ovs:
    assert property (mode == MODE_STANDBY ##1 mode == MODE_WAKE |->
      eff_ovs == ctrl.ovs_mode && low_power == (ctrl.ovs_mode == OVS_LOW_POWER))
    else $error("oversampling or low power wrong");
  a_upper_only_lower:
    assert property ($changed(out[0]) && ctrl.active && ctrl.upper_only |->
      out[0].lower == 8'h00)
    else $error("lower byte filled in upper-only read");
  a_route_pin_two:
    assert property ($rose(int_two_r) |->
      |($past(events, 3) & event_route) || |($past(events, 4) & event_route))
    else $error("pin two raised without routed event");
endmodule

bind accel_mode_and_data_format accel_mode_checker #(
  .EXTRA_CYCLES(EXTRA_CYCLES), .EVENTS(EVENTS)
) chk_u (.core_clk, .rst, .ctrl, .events, .event_route, .bus_ready, .analog_en,
  .clocks_en, .mode, .data_valid_r, .out, .eff_range, .eff_ovs, .low_power,
  .lsb_ug, .int_two_r);

/* File: test_accel_mode_and_data_format.sv */
// self-checking bench for the power-mode and data-format block
`timescale 1ns/10ps
module test_accel_mode_and_data_format
  import accel_pkg::*;
;
  typedef struct {ctrl_s c; sample_t r; range_e er; logic [15:0] lsb; logic lp;} row_s;
  logic core_clk, rst, supply_ok, sample_tick, sleep_req, wake_req, offset_wr;
  logic bus_ready, analog_en, clocks_en, data_valid_r, low_power, int_one_r, int_two_r;
  ctrl_s       ctrl;
  sample_t     raw [NUM_AXES];
  sample_t     user_offset [NUM_AXES];
  sample_t     uo_cur;        // offset the design should hold
  logic [3:0]  events;
  logic [3:0]  event_route;
  logic [1:0]  trim_addr;
  logic [1:0]  eff_ovs;
  trim_s       trim_data;
  mode_e       mode;
  out_pair_s   out [NUM_AXES];
  range_e      eff_range;
  logic [15:0] lsb_ug;
  logic [2:0]  tick_cnt_r;    // output period divider
  int          errors, checks_done;
  // config rows with expected range, weight and low-power flag
  row_s rows [5] = '{
    '{'{1'b0, 1'b0, 1'b0, RANGE_2G, 2'h0}, 14'h0123, RANGE_2G, 16'h00F4, 1'b1},
    '{'{1'b0, 1'b0, 1'b0, RANGE_8G, 2'h1}, 14'h3F00, RANGE_8G, 16'h03D0, 1'b0},
    '{'{1'b0, 1'b1, 1'b0, RANGE_4G, 2'h2}, 14'h1FFF, RANGE_4G, 16'h01E8, 1'b0},
    '{'{1'b0, 1'b0, 1'b1, RANGE_8G, 2'h3}, 14'h2000, RANGE_4G, 16'h01E8, 1'b0},
    '{'{1'b0, 1'b1, 1'b1, RANGE_2G, 2'h0}, 14'h0040, RANGE_4G, 16'h01E8, 1'b1}};

  accel_mode_and_data_format #(.BOOT_CYCLES(20), .EXTRA_CYCLES(10), .EVENTS(4)) dut_u (
    .core_clk, .rst, .supply_ok, .ctrl, .sample_tick, .sleep_req, .wake_req, .raw,
    .user_offset, .offset_wr, .events, .event_route, .trim_addr, .trim_data,
    .bus_ready, .analog_en, .clocks_en, .mode, .data_valid_r, .out, .eff_range,
    .eff_ovs, .low_power, .lsb_ug, .int_one_r, .int_two_r);
  trim_store_model store_u (.trim_addr, .trim_data);

  // clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // one tick every eight cycles; reset keeps the divider single-driven
  always @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_r  <= 3'h0;
      sample_tick <= 1'b0;
    end else begin
      tick_cnt_r  <= tick_cnt_r + 3'h1;
      sample_tick <= (tick_cnt_r == 3'h7);
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for a power mode
  task automatic wait_mode(mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("mode", mode, m);
  endtask
  // expected bytes: raw plus trim and user offset, saturated
  function automatic out_pair_s fmt(int ax, sample_t r, sample_t u, logic uo);
    logic signed [15:0] s;
    sample_t            v;
    s = 16'(r) + 16'(u) + 16'(16 * (ax + 1));
    if (s > 16'sh1FFF) v = 14'h1FFF;
    else if (s < -16'sh2000) v = 14'h2000;
    else v = s[13:0];
    return {v[13:6], uo ? 8'h00 : {v[5:0], 2'b00}};
  endfunction
  // standby, set config, go active, wait for loaded data
  task automatic activate(ctrl_s c, sample_t r);
    int n;
    c.active = 1'b0;
    @(posedge core_clk) begin
      ctrl <= c;
      foreach (raw[a]) raw[a] <= r;
    end
    wait_mode(MODE_STANDBY);
    c.active = 1'b1;
    @(posedge core_clk) ctrl <= c;
    wait_mode(MODE_WAKE);
    check("valid", data_valid_r, 1'b0);
    check("out", out[0], 16'h0000);
    n = 0;
    while (data_valid_r !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("valid", data_valid_r, 1'b1);
    // two 8-cycle tick periods plus 10 extra cycles, tick phase unknown
    check("wake_cycles", (n >= 19) && (n <= 26), 1'b1);
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  task automatic outs(sample_t r, logic uo);
    foreach (out[a]) check("out", out[a], fmt(a, r, uo_cur, uo));
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    results();
  end

  initial begin
    {rst, supply_ok, sleep_req, wake_req, offset_wr} = '0;
    rst = 1'b1;
    ctrl = '0;
    events = 4'h0;
    event_route = 4'h5;
    uo_cur = '0;
    foreach (raw[a]) raw[a] = '0;
    foreach (user_offset[a]) user_offset[a] = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    supply_ok <= 1'b1;
    wait_mode(MODE_STANDBY);
    // table of configurations
    foreach (rows[i]) begin
      activate(rows[i].c, rows[i].r);
      check("range", eff_range, rows[i].er);
      check("lsb", lsb_ug, rows[i].lsb);
      check("lowpow", low_power, rows[i].lp);
      check("ovs", eff_ovs, rows[i].c.ovs_mode);
      outs(rows[i].r, rows[i].c.upper_only);
      $display("test row %0d done", i);
    end
    // back to standby keeps data, gates analog
    @(posedge core_clk) ctrl.active <= 1'b0;
    wait_mode(MODE_STANDBY);
    repeat (20) @(posedge core_clk);
    #1;
    outs(rows[4].r, 1'b1);
    check("gates", {analog_en, clocks_en, bus_ready}, 3'b001);
    $display("test standby done");
    // offset write, negative saturation
    @(posedge core_clk) begin
      foreach (user_offset[a]) user_offset[a] <= 14'h3F00;
      offset_wr <= 1'b1;
    end
    @(posedge core_clk) offset_wr <= 1'b0;
    uo_cur = 14'h3F00;
    activate(rows[0].c, 14'h2000);
    outs(14'h2000, 1'b0);
    $display("test offset done");
    // sleep and wake stay fully powered
    @(posedge core_clk) sleep_req <= 1'b1;
    wait_mode(MODE_SLEEP);
    check("gates", {analog_en, clocks_en, bus_ready}, 3'b111);
    @(posedge core_clk) begin
      sleep_req <= 1'b0;
      wake_req <= 1'b1;
    end
    wait_mode(MODE_WAKE);
    @(posedge core_clk) wake_req <= 1'b0;
    $display("test sleep done");
    // event routing to both pins
    @(posedge core_clk) events <= 4'h2;
    repeat (6) @(posedge core_clk);
    #1;
    check("pins", {int_one_r, int_two_r}, 2'b10);
    @(posedge core_clk) events <= 4'h4;
    repeat (6) @(posedge core_clk);
    #1;
    check("pins", {int_one_r, int_two_r}, 2'b01);
    @(posedge core_clk) events <= 4'h0;
    $display("test events done");
    // supply loss, refused offset write, reboot
    @(posedge core_clk) begin
      supply_ok <= 1'b0;
      ctrl.active <= 1'b0;
    end
    wait_mode(MODE_OFF);
    check("bus", {bus_ready, analog_en}, 2'b00);
    @(posedge core_clk) begin
      foreach (user_offset[a]) user_offset[a] <= 14'h0100;
      offset_wr <= 1'b1;
    end
    @(posedge core_clk) offset_wr <= 1'b0;
    @(posedge core_clk) supply_ok <= 1'b1;
    wait_mode(MODE_STANDBY);
    activate(rows[1].c, 14'h0100);
    outs(14'h0100, 1'b0);
    $display("test supply done");
    // reset in mid-run
    @(posedge core_clk) begin
      rst <= 1'b1;
      ctrl.active <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    #1;
    check("mode", mode, MODE_OFF);
    check("lsb", lsb_ug, 16'h00F4);
    check("state", {data_valid_r, int_one_r, int_two_r, out[0]}, 19'h0_0000);
    @(posedge core_clk) rst <= 1'b0;
    wait_mode(MODE_STANDBY);
    $display("test reset done");
    results();
  end
endmodule
